// file: trap_pkg.sv
// Package holding the encodings and layout constants of the conditional trap unit.
// Assumes a 32-bit instruction word and 32-bit general registers.
package trap_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W      = 32;         // Instruction and operand width.
	localparam int unsigned OPC_HI      = 31;         // Primary opcode top bit.
	localparam int unsigned OPC_LO      = 26;         // Primary opcode bottom bit.
	localparam int unsigned SUB_HI      = 20;         // Immediate sub-opcode top bit.
	localparam int unsigned SUB_LO      = 16;         // Immediate sub-opcode bottom bit.
	localparam int unsigned FN_HI       = 5;          // Function field top bit.
	localparam int unsigned FN_LO       = 0;          // Function field bottom bit.
	localparam int unsigned IMM_HI      = 15;         // Immediate top bit.
	localparam int unsigned IMM_LO      = 0;          // Immediate bottom bit.
	localparam int unsigned CODE_HI     = 15;         // Software code field top bit.
	localparam int unsigned CODE_LO     = 6;          // Software code field bottom bit.

	// ----------------------------------------------------------------
	// Opcode encodings
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_FUNCTION_CODED_OPCODE_GROUP = 6'h00; // Function-coded group.
	localparam logic [5:0] OPC_REGISTER_IMMEDIATE_OPCODE_GROUP = 6'h01; // Immediate group.
	localparam logic [5:0] FN_TRAP_LT_REG_SIGNED   = 6'h32; // Register signed less-than.
	localparam logic [5:0] FN_TRAP_LT_REG_UNSIGNED = 6'h33; // Register unsigned less-than.
	localparam logic [5:0] FN_TRAP_NE_REG          = 6'h36; // Register not-equal.
	localparam logic [4:0] SUB_TRAP_LT_IMM_SIGNED   = 5'h0a; // Immediate signed less-than.
	localparam logic [4:0] SUB_TRAP_LT_IMM_UNSIGNED = 5'h0b; // Immediate unsigned less-than.
	localparam logic [4:0] SUB_TRAP_NE_IMM          = 5'h0e; // Immediate not-equal.

	// ----------------------------------------------------------------
	// Architecture release and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  RELEASE_IMM_WITHDRAWN = 4'h6;   // Release lacking immediate traps.
	localparam logic        TRAP_RESET            = 1'b0;   // Trap output after reset.
	localparam logic [31:0] WORD_RESET            = 32'h0;  // Word registers after reset.

	// Trap form selected by the decoder.
	typedef enum logic [2:0] {
		FORM_NONE    = 3'b000,
		FORM_LT_S    = 3'b001,
		FORM_LT_U    = 3'b010,
		FORM_NE      = 3'b011,
		FORM_LT_IS   = 3'b100,
		FORM_LT_IU   = 3'b101,
		FORM_NE_I    = 3'b110
	} trap_form_t;

endpackage

// file: trap_decoder.sv
// Decoder that names the trap form held in an instruction word.
// Assumes the word is stable in the cycle it is presented; purely combinational.
`timescale 1ns/1ps
module trap_decoder
	import trap_pkg::*;
(
	input  wire logic [31:0]          i_insn,        // Instruction word.
	input  wire logic [3:0]           i_release,     // Configured architecture release.
	output trap_pkg::trap_form_t      o_form,        // Decoded trap form.
	output logic                      o_uses_imm     // High for immediate forms.
);
	import trap_pkg::*;

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	logic [5:0] opc;   // Primary opcode.
	logic [5:0] fn;    // Function field.
	logic [4:0] sub;   // Immediate sub-opcode.
	logic       imm_ok; // Immediate forms exist in this release.

	// Split the word; the software code field is never read here.
	always_comb begin
		opc    = i_insn[OPC_HI:OPC_LO];
		fn     = i_insn[FN_HI:FN_LO];
		sub    = i_insn[SUB_HI:SUB_LO];
		imm_ok = (i_release != RELEASE_IMM_WITHDRAWN);
	end

	// Priority-free decode: each form has a unique opcode pair.
	always_comb begin
		o_form = FORM_NONE;
		if (opc == OPC_FUNCTION_CODED_OPCODE_GROUP) begin
			if (fn == FN_TRAP_LT_REG_SIGNED) begin
				o_form = FORM_LT_S;
			end else if (fn == FN_TRAP_LT_REG_UNSIGNED) begin
				o_form = FORM_LT_U;
			end else if (fn == FN_TRAP_NE_REG) begin
				o_form = FORM_NE;
			end
		end else if (opc == OPC_REGISTER_IMMEDIATE_OPCODE_GROUP && imm_ok) begin
			if (sub == SUB_TRAP_LT_IMM_SIGNED) begin
				o_form = FORM_LT_IS;
			end else if (sub == SUB_TRAP_LT_IMM_UNSIGNED) begin
				o_form = FORM_LT_IU;
			end else if (sub == SUB_TRAP_NE_IMM) begin
				o_form = FORM_NE_I;
			end
		end
		o_uses_imm = (o_form == FORM_LT_IS) || (o_form == FORM_LT_IU) || (o_form == FORM_NE_I);
	end

endmodule

// file: trap_compare.sv
// Comparator giving signed less-than, unsigned less-than and not-equal of two words.
// Assumes both operands are already 32 bits wide; purely combinational.
`timescale 1ns/1ps
module trap_compare
	import trap_pkg::*;
(
	input  wire logic [31:0] i_a,        // First operand.
	input  wire logic [31:0] i_b,        // Second operand.
	output logic             o_lt_s,     // First below second, signed.
	output logic             o_lt_u,     // First below second, unsigned.
	output logic             o_ne        // Operands differ in some bit.
);
	import trap_pkg::*;

	// One subtraction serves both orderings, which saves a second carry chain.
	logic [32:0] diff; // Zero-extended difference, carry out in bit 32.

	// Borrow gives unsigned order; sign bits fix it up for signed order.
	always_comb begin
		diff   = {1'b0, i_a} - {1'b0, i_b};
		o_lt_u = diff[32];
		if (i_a[31] != i_b[31]) begin
			o_lt_s = i_a[31];
		end else begin
			o_lt_s = diff[32];
		end
		o_ne   = (i_a != i_b);
	end

endmodule

// file: conditional_trap_unit.sv
// Conditional trap unit: decodes the six trap forms, compares, raises a trap request.
// Assumes operands arrive from the register file in the same cycle as the valid word.
// Functional notes
// - Register signed less-than traps when first smaller.
// - Register unsigned less-than traps when first smaller.
// - Register not-equal traps when any bit differs.
// - Immediate signed less-than uses sign-extended immediate.
// - Immediate unsigned less-than sign-extends, compares unsigned.
// - Immediate not-equal compares with sign-extended immediate.
// - Software code field never affects the decision.
// - Register signed form: opcode 000000, function 110010.
// - Immediate signed form: opcode 000001, field 01010.
// - Immediate unsigned form: opcode 000001, field 01011.
// - Immediate not-equal form: opcode 000001, field 01110.
// - Immediate forms withdrawn in release six.
// - Unsigned immediate thresholds only at range ends.
`timescale 1ns/1ps
module conditional_trap_unit
	import trap_pkg::*;
(
	input  wire logic        i_ref_clk,     // Core clock, 200 MHz.
	input  wire logic        i_rstn,        // Asynchronous active-low reset.
	input  wire logic        i_valid,       // Instruction word and operands valid.
	input  wire logic [31:0] i_insn,        // Instruction word.
	input  wire logic [31:0] i_first_source_reg,  // Value of the first source register.
	input  wire logic [31:0] i_second_source_reg, // Value of the second source register.
	input  wire logic [3:0]  i_release,     // Configured architecture release, held static.
	output logic             o_trap,        // Trap request, one-cycle pulse.
	output logic             o_trap_insn_valid, // Valid trap-form instruction seen, pulse.
	output logic [31:0]      o_trap_insn    // Word of the last evaluated trap form.
);
	import trap_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_r; // First stage, read only by the second.
	logic rst_sync_r; // Released reset used by the rest of the block.

	// Assertion is immediate; release waits two clock edges to avoid metastability.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Decode and operand selection
	// ----------------------------------------------------------------
	trap_form_t  form;       // Decoded trap form.
	logic        uses_imm;   // Form compares against the immediate.
	logic [31:0] imm_ext;    // Sign-extended immediate.
	logic [31:0] opnd_b;     // Second comparison operand.
	logic        lt_s;       // Signed less-than result.
	logic        lt_u;       // Unsigned less-than result.
	logic        ne;         // Not-equal result.
	logic        cond;       // Trap condition of the current form.

	trap_decoder u_trap_decoder (
		.i_insn     (i_insn),
		.i_release  (i_release),
		.o_form     (form),
		.o_uses_imm (uses_imm)
	);

	// Immediate forms sign-extend; register forms take the second register whole.
	always_comb begin
		imm_ext = {{16{i_insn[IMM_HI]}}, i_insn[IMM_HI:IMM_LO]};
		// Unsigned immediate also sign-extends, so only the range ends are reachable.
		opnd_b  = uses_imm ? imm_ext : i_second_source_reg;
	end

	trap_compare u_trap_compare (
		.i_a    (i_first_source_reg),
		.i_b    (opnd_b),
		.o_lt_s (lt_s),
		.o_lt_u (lt_u),
		.o_ne   (ne)
	);

	// Pick the comparison that the form asks for; bits 15:6 play no part.
	always_comb begin
		case (form)
			FORM_LT_S:  cond = lt_s;
			FORM_LT_U:  cond = lt_u;
			FORM_NE:    cond = ne;
			FORM_LT_IS: cond = lt_s;
			FORM_LT_IU: cond = lt_u;
			FORM_NE_I:  cond = ne;
			default:    cond = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	logic        trap_nxt;  // Next trap pulse.
	logic        seen_nxt;  // Next trap-form pulse.
	logic [31:0] word_nxt;  // Next captured word.
	logic        trap_r;    // Registered trap pulse.
	logic        seen_r;    // Registered trap-form pulse.
	logic [31:0] word_r;    // Captured word, held until the next trap form.

	// A false condition leaves the trap low; the pipeline simply moves on.
	always_comb begin
		trap_nxt = i_valid && cond;
		seen_nxt = i_valid && (form != FORM_NONE);
		word_nxt = seen_nxt ? i_insn : word_r;
	end

	// Registers only; all decisions live in the process above.
	always_ff @(posedge i_ref_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			trap_r <= TRAP_RESET;
			seen_r <= TRAP_RESET;
			word_r <= WORD_RESET;
		end else begin
			trap_r <= trap_nxt;
			seen_r <= seen_nxt;
			word_r <= word_nxt;
		end
	end

	always_comb begin
		o_trap            = trap_r;
		o_trap_insn_valid = seen_r;
		o_trap_insn       = word_r;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [31:0] sx_imm; // Helper sign extension independent of the datapath.
	assign sx_imm = {{16{i_insn[15]}}, i_insn[15:0]};

	logic is_rr;   // Register group opcode.
	logic is_ri;   // Immediate group opcode, release permitting.
	assign is_rr = (i_insn[31:26] == 6'h00);
	assign is_ri = (i_insn[31:26] == 6'h01) && (i_release != 4'h6);

	property p_lt_reg_s;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_rr && i_insn[5:0] == 6'h32) |=>
			(o_trap == ($signed($past(i_first_source_reg)) < $signed($past(i_second_source_reg))));
	endproperty
	a_lt_reg_s: assert property (p_lt_reg_s) else $error("signed register trap wrong");

	property p_lt_reg_u;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_rr && i_insn[5:0] == 6'h33) |=>
			(o_trap == ($past(i_first_source_reg) < $past(i_second_source_reg)));
	endproperty
	a_lt_reg_u: assert property (p_lt_reg_u) else $error("unsigned register trap wrong");

	property p_ne_reg;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_rr && i_insn[5:0] == 6'h36) |=>
			(o_trap == ($past(i_first_source_reg) != $past(i_second_source_reg)));
	endproperty
	a_ne_reg: assert property (p_ne_reg) else $error("not-equal register trap wrong");

	property p_lt_imm_s;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_ri && i_insn[20:16] == 5'h0a) |=>
			(o_trap == ($signed($past(i_first_source_reg)) < $signed($past(sx_imm))));
	endproperty
	a_lt_imm_s: assert property (p_lt_imm_s) else $error("signed immediate trap wrong");

	property p_lt_imm_u;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_ri && i_insn[20:16] == 5'h0b) |=>
			(o_trap == ($past(i_first_source_reg) < $past(sx_imm)));
	endproperty
	a_lt_imm_u: assert property (p_lt_imm_u) else $error("unsigned immediate trap wrong");

	property p_ne_imm;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && is_ri && i_insn[20:16] == 5'h0e) |=>
			(o_trap == ($past(i_first_source_reg) != $past(sx_imm)));
	endproperty
	a_ne_imm: assert property (p_ne_imm) else $error("not-equal immediate trap wrong");

	sequence s_withdrawn_imm;
		i_valid && i_insn[31:26] == 6'h01 && i_release == 4'h6;
	endsequence
	property p_withdrawn;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_withdrawn_imm |=> (!o_trap && !o_trap_insn_valid);
	endproperty
	a_withdrawn: assert property (p_withdrawn) else $error("withdrawn form trapped");

	property p_idle_no_trap;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		!i_valid |=> !o_trap;
	endproperty
	a_idle_no_trap: assert property (p_idle_no_trap) else $error("trap without valid");

	property p_trap_is_form;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		o_trap |-> (o_trap_insn_valid && o_trap_insn == $past(i_insn));
	endproperty
	a_trap_is_form: assert property (p_trap_is_form) else $error("trap without form");

	// ----------------------------------------------------------------
	// Recognition, hold and reset checks
	// ----------------------------------------------------------------
	logic is_rr_form; // Register group word carrying one of the three trap functions.
	logic is_ri_form; // Immediate group word carrying one of the three trap sub-opcodes.
	assign is_rr_form = is_rr && (i_insn[5:0] == 6'h32 || i_insn[5:0] == 6'h33 ||
		i_insn[5:0] == 6'h36);
	assign is_ri_form = is_ri && (i_insn[20:16] == 5'h0a || i_insn[20:16] == 5'h0b ||
		i_insn[20:16] == 5'h0e);

	// A register trap word offered; bits 15:6 are left free on purpose.
	sequence s_rr_offer;
		i_valid && is_rr_form;
	endsequence

	// The signed register form offered.
	sequence s_lt_rs_offer;
		i_valid && is_rr && i_insn[5:0] == 6'h32;
	endsequence

	// The three immediate forms offered, each in a release that still has them.
	sequence s_lt_is_offer;
		i_valid && is_ri && i_insn[20:16] == 5'h0a;
	endsequence
	sequence s_lt_iu_offer;
		i_valid && is_ri && i_insn[20:16] == 5'h0b;
	endsequence
	sequence s_ne_i_offer;
		i_valid && is_ri && i_insn[20:16] == 5'h0e;
	endsequence

	// The answer step: the form is flagged on the cycle after it was taken.
	sequence s_form_flagged;
		o_trap_insn_valid;
	endsequence

	// Unsigned immediate with a low threshold, register above the whole low range.
	sequence s_iu_low_end;
		s_lt_iu_offer ##0 (!i_insn[15] && i_first_source_reg > 32'h00007fff);
	endsequence

	// Unsigned immediate with a high threshold, register below the whole high range.
	sequence s_iu_high_end;
		s_lt_iu_offer ##0 (i_insn[15] && i_first_source_reg < 32'hffff8000);
	endsequence

	// Whatever the code bits hold, a register trap word is still recognised.
	property p_rr_seen;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_rr_offer |=> s_form_flagged;
	endproperty
	a_rr_seen: assert property (p_rr_seen) else $error("register trap form missed");

	// The signed register form is flagged and its whole word captured.
	property p_lt_rs_seen;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_lt_rs_offer |=> s_form_flagged ##0 (o_trap_insn == $past(i_insn));
	endproperty
	a_lt_rs_seen: assert property (p_lt_rs_seen) else $error("signed register form missed");

	// Each immediate form is recognised while the release still carries it.
	property p_lt_is_seen;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_lt_is_offer |=> s_form_flagged;
	endproperty
	a_lt_is_seen: assert property (p_lt_is_seen) else $error("signed immediate form missed");

	property p_lt_iu_seen;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_lt_iu_offer |=> s_form_flagged;
	endproperty
	a_lt_iu_seen: assert property (p_lt_iu_seen) else $error("unsigned immediate form missed");

	property p_ne_i_seen;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_ne_i_offer |=> s_form_flagged;
	endproperty
	a_ne_i_seen: assert property (p_ne_i_seen) else $error("not-equal immediate form missed");

	// A word of no trap form leaves both pulses low.
	property p_stray_quiet;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		(i_valid && !is_rr_form && !is_ri_form) |=> (!o_trap && !o_trap_insn_valid);
	endproperty
	a_stray_quiet: assert property (p_stray_quiet) else $error("stray word flagged");

	// Without a new form the captured word must not move.
	property p_word_held;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		!o_trap_insn_valid |-> $stable(o_trap_insn);
	endproperty
	a_word_held: assert property (p_word_held) else $error("captured word moved");

	// Low threshold end: a register above 32767 can never trap.
	property p_iu_low_end;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_iu_low_end |=> !o_trap;
	endproperty
	a_iu_low_end: assert property (p_iu_low_end) else $error("low threshold trapped");

	// High threshold end: a register below the high range always traps.
	property p_iu_high_end;
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		s_iu_high_end |=> o_trap;
	endproperty
	a_iu_high_end: assert property (p_iu_high_end) else $error("high threshold missed");

	// While reset is held every output sits at its reset value; no disable on purpose.
	property p_reset_quiet;
		@(posedge i_ref_clk)
		!rst_sync_r |-> (o_trap == TRAP_RESET && !o_trap_insn_valid &&
			o_trap_insn == WORD_RESET);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");

endmodule

// file: pipe_source_model.sv
// Model of the register file that feeds operands to the conditional trap unit.
// Assumes the bench writes it only while no word is offered; reads are combinational.
`timescale 1ns/1ps
module pipe_source_model (
	input  wire logic        i_clk,                // Core clock.
	input  wire logic        i_we,                 // Write strobe.
	input  wire logic [4:0]  i_waddr,              // Register written.
	input  wire logic [31:0] i_wdata,              // Value written.
	input  wire logic [31:0] i_insn,               // Word whose fields select the sources.
	output logic      [31:0] o_first_source_reg,   // First source value.
	output logic      [31:0] o_second_source_reg   // Second source value.
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [31:0] regs_r [32] = '{default: 32'h0};  // Cleared so no unknown reaches the unit.

	// Registered write, as a real file would take it on the clock.
	always @(posedge i_clk) begin
		if (i_we) begin
			regs_r[i_waddr] <= i_wdata;
		end
	end

	// Source fields sit in bits 25:21 and 20:16 of every word.
	assign o_first_source_reg  = regs_r[i_insn[25:21]];
	assign o_second_source_reg = regs_r[i_insn[20:16]];
endmodule

// file: tb_conditional_trap_unit.sv
// Self-checking bench of the conditional trap unit with a register file model.
// Assumes one-cycle registered answers and two synchroniser edges after reset.
`timescale 1ns/1ps
module tb_conditional_trap_unit;
	import trap_pkg::*;
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed { logic trap; logic [31:0] word; } note_t;
	logic        i_ref_clk = 1'b0;      // Core clock.
	logic        i_rstn    = 1'b0;      // Reset, active low.
	logic        i_valid   = 1'b0;      // Offer strobe.
	logic [31:0] i_insn    = 32'h0;     // Offered word.
	logic [3:0]  i_release = 4'h2;      // Release, changed only while idle.
	logic        we = 1'b0;             // Register file write strobe.
	logic [4:0]  waddr = 5'h0;          // Register file write index.
	logic [31:0] wdata = 32'h0;         // Register file write value.
	wire  [31:0] first_val, second_val; // Operands from the model.
	logic        o_trap, o_trap_insn_valid;
	logic [31:0] o_trap_insn;
	logic [31:0] mirror [32] = '{default: 32'h0}; // Bench copy of the file.
	logic [31:0] last_word = 32'h0;     // Word the unit should be holding.
	note_t       notes[$];              // Expected answers, oldest first.
	int          n_errors = 0, comparisons = 0, seed = 32'hccf1;
	logic [5:0]  fns [3] = '{6'h32, 6'h33, 6'h36};
	logic [4:0]  subs[3] = '{5'h0a, 5'h0b, 5'h0e};
	logic [15:0] imms[8] = '{16'h0, 16'h1, 16'h7fff, 16'h8000, 16'hffff, 16'h8001, 16'h7ffe, 16'h1234};
	logic [31:0] bnd [8] = '{32'h0, 32'h1, 32'h7fff, 32'h8000, 32'hffff8000, 32'hffffffff,
		32'h80000000, 32'h7fffffff};

	always #2.5 i_ref_clk = ~i_ref_clk;

	conditional_trap_unit u_conditional_trap_unit (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_valid(i_valid), .i_insn(i_insn), .i_first_source_reg(first_val),
		.i_second_source_reg(second_val), .i_release(i_release), .o_trap(o_trap),
		.o_trap_insn_valid(o_trap_insn_valid), .o_trap_insn(o_trap_insn));
	pipe_source_model u_pipe_source_model (.i_clk(i_ref_clk), .i_we(we), .i_waddr(waddr),
		.i_wdata(wdata), .i_insn(i_insn), .o_first_source_reg(first_val),
		.o_second_source_reg(second_val));

	// ------------------------------------------------------------
	// Reference: returns {recognised, trap} from literal encodings.
	// ------------------------------------------------------------
	function automatic logic [1:0] expect_of(logic [31:0] w, logic [31:0] a, logic [31:0] b,
		logic [3:0] rel);
		logic [31:0] imm;
		imm = {{16{w[15]}}, w[15:0]};
		expect_of = 2'b00;
		if (w[31:26] == 6'h00) begin
			case (w[5:0])
				6'h32:   expect_of = {1'b1, $signed(a) < $signed(b)};
				6'h33:   expect_of = {1'b1, a < b};
				6'h36:   expect_of = {1'b1, a != b};
				default: expect_of = 2'b00;
			endcase
		end else if (w[31:26] == 6'h01 && rel != 4'h6) begin
			case (w[20:16])
				5'h0a:   expect_of = {1'b1, $signed(a) < $signed(imm)};
				5'h0b:   expect_of = {1'b1, a < imm};
				5'h0e:   expect_of = {1'b1, a != imm};
				default: expect_of = 2'b00;
			endcase
		end
	endfunction

	// Builds form f (0..5) from source x, second source or immediate y, random code r.
	function automatic logic [31:0] mk(int f, int x, int y, logic [31:0] r);
		if (f < 3) begin
			mk = {6'h00, x[4:0], y[4:0], r[9:0], fns[f]};
		end else begin
			mk = {6'h01, x[4:0], subs[f-3], imms[y[2:0]]};
		end
	endfunction

	// ------------------------------------------------------------
	// Drivers: one call per cycle, entered just after a rising edge.
	// ------------------------------------------------------------
	task automatic issue(input logic [31:0] w, input logic v);
		logic [1:0] e;
		e = expect_of(w, mirror[w[25:21]], mirror[w[20:16]], i_release);
		i_valid <= v;
		i_insn  <= w;
		we      <= 1'b0;
		if (v && e[1]) begin
			notes.push_back('{e[0], w});
		end
		@(posedge i_ref_clk);
	endtask

	// Writes happen with no word offered, so operand and mirror never disagree.
	// The strobe stays up across back-to-back writes; the next issue lowers it.
	task automatic wr(input int idx, input logic [31:0] val);
		i_valid <= 1'b0;
		we      <= 1'b1;
		waddr   <= idx[4:0];
		wdata   <= val;
		mirror[idx] = val;
		@(posedge i_ref_clk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Monitor: settled outputs are read at the falling edge.
	// ------------------------------------------------------------
	always @(negedge i_ref_clk) begin
		note_t n;
		if (o_trap_insn_valid === 1'b1) begin
			n = (notes.size() > 0) ? notes.pop_front() : note_t'{1'b0, ~o_trap_insn};
			`CHK("o_trap", n.trap, o_trap)
			`CHK("o_trap_insn", n.word, o_trap_insn)
			last_word = n.word;
		end else begin
			`CHK("o_trap idle", 1'b0, o_trap)
			`CHK("o_trap_insn held", last_word, o_trap_insn)
		end
	end

	// Cuts a hang short; the whole run needs about 1240 cycles.
	initial begin
		#50000;
		n_errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		for (int k = 0; k < 32; k++) begin
			wr(k, (k < 8) ? bnd[k] : $random(seed));
		end
		// Every form against boundary pairs, back to back, then the release that drops
		// the immediate forms.
		for (int r = 0; r < 2; r++) begin
			i_release <= (r == 0) ? 4'h2 : 4'h6;
			issue(32'h0, 1'b0);
			for (int f = 0; f < 6; f++) begin
				for (int x = 0; x < 8; x++) begin
					for (int y = 0; y < 8; y++) begin
						issue(mk(f, x, y, $random(seed)), 1'b1);
					end
				end
			end
			issue({6'h00, 20'h12345, 6'h34}, 1'b1);
			issue({6'h01, 5'h3, 5'h0c, 16'h8000}, 1'b1);
		end
		// Mid-run reset: every output clears, the held word included.
		issue(32'h0, 1'b0);
		i_rstn    <= 1'b0;
		last_word = 32'h0;
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		// Random traffic, with rewrites of the file and stray words mixed in.
		i_release <= 4'h2;
		for (int i = 0; i < 400; i++) begin
			if (i % 50 == 0) begin
				wr($unsigned($random(seed)) % 32, $random(seed));
			end
			issue(($random(seed) % 4 == 0) ? $random(seed) :
				mk($unsigned($random(seed)) % 6, $random(seed), $random(seed), $random(seed)),
				$random(seed));
		end
		issue(32'h0, 1'b0);
		repeat (3) @(posedge i_ref_clk);
		`CHK("notes left", 0, notes.size())
		report_and_stop();
	end
endmodule
